// ---- design/ipf_parallel_rx.sv ----
// Purpose: Parallel capture unit: 20 data bits, clock and clock hold.
// Assumes: Capture clock well below aclk/3.
// Notes: Packing phase restarts whenever the unit is disabled.
`timescale 1ns/1ps
module ipf_parallel_rx (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic en,
	input wire logic fall_edge,
	input wire logic [1:0] mode,
	input wire logic cap_clock,
	input wire logic hold,
	input wire logic [19:0] cap_data,
	input wire logic ack,
	output logic word_valid_q,
	output logic [31:0] word_q
);
	logic [21:0] s1_q, s2_q, s3_q, st_q, prev_q;
	logic [1:0] phase_q;
	logic [31:0] acc_q;
	wire [21:0] st_d = (s2_q & ~(s2_q ^ s3_q)) | (st_q & (s2_q ^ s3_q));
	wire [19:0] d = st_q[19:0];
	wire edge_hit = fall_edge ? (prev_q[20] & ~st_q[20]) : (st_q[20] & ~prev_q[20]);
	wire take = en & edge_hit & ~st_q[21];
	// Four packings: 20 right, 2x16, 4x8, 20 left
	wire [31:0] acc_d = (mode == 2'd1) ? {acc_q[15:0], d[15:0]} :
		(mode == 2'd2) ? {acc_q[23:0], d[7:0]} :
		(mode == 2'd3) ? {d, 12'h0} : {12'h0, d};
	wire last = (mode == 2'd1) ? (phase_q == 2'd1) :
		(mode == 2'd2) ? (phase_q == 2'd3) : 1'b1;

	// Synchroniser chain
	always_ff @(posedge aclk) begin
		s1_q <= {hold, cap_clock, cap_data};
		s2_q <= s1_q;
		s3_q <= s2_q;
		st_q <= st_d;
		prev_q <= st_q;
	end

	// Latch on the chosen edge, emit a word when packing completes
	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			phase_q <= 2'd0;
			acc_q <= 32'h0;
			word_q <= 32'h0;
			word_valid_q <= 1'b0;
		end else begin
			if (ack)
				word_valid_q <= 1'b0;
			if (take) begin
				acc_q <= acc_d;
				phase_q <= last ? 2'd0 : phase_q + 2'd1;
				if (last) begin
					word_q <= acc_d;
					word_valid_q <= 1'b1;
				end
			end
		end
	end
endmodule

// ---- design/ipf_pkg.sv ----
// Purpose: Shared constants and types of the audio input port block.
// Assumes: 32-bit register bus, one aligned word per register.
// Notes: Byte offsets are 12-bit; upper address bits are ignored.
package ipf_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_CTL0 = 12'h000;
	localparam logic [11:0] OFF_CTL1 = 12'h004;
	localparam logic [11:0] OFF_PP_CTL = 12'h008;
	localparam logic [11:0] OFF_FIFO = 12'h00c;
	localparam logic [11:0] OFF_PTR_STAT = 12'h010;
	localparam logic [11:0] OFF_RE_MASK = 12'h014;
	localparam logic [11:0] OFF_FE_MASK = 12'h018;
	localparam logic [11:0] OFF_PRI = 12'h01c;
	localparam logic [11:0] OFF_LAT_LOW = 12'h020;
	localparam logic [11:0] OFF_LAT_HIGH = 12'h024;
	localparam logic [11:0] OFF_ROUTE_STAT = 12'h028;
	// Per-channel transfer parameters: base + ch*16 + slot*4
	localparam logic [3:0] PRM_PAGE = 4'h1;
	localparam logic [1:0] PRM_IDX_A = 2'h0;
	localparam logic [1:0] PRM_IDX_B = 2'h1;
	localparam logic [1:0] PRM_MOD = 2'h2;
	localparam logic [1:0] PRM_CNT = 2'h3;
	// Field positions
	localparam int CTL0_NSET_LSB = 0;
	localparam int CTL0_STALL_DIS_BIT = 4;
	localparam int CTL0_CLR_OVF_BIT = 6;
	localparam int CTL0_PORT_EN_BIT = 7;
	localparam int CTL0_GDMA_BIT = 8;
	localparam int CTL1_CHDMA_LSB = 8;
	localparam int CTL1_PING_LSB = 16;
	localparam int PP_EN_BIT = 31;
	localparam int PP_EDGE_BIT = 29;
	localparam int PP_MODE_LSB = 26;
	localparam int EV_THR_BIT = 8;
	localparam int EV_DONE_LSB = 10;
	localparam int ST_ACT_LSB = 17;
	localparam int PTR_WR_LSB = 4;
	localparam int PTR_CNT_LSB = 8;
	// Reset values
	localparam logic [17:0] EV_RST = 18'h00000;
	localparam logic [23:0] CTL1_RST = 24'h000000;
	localparam logic [3:0] NSET_RST = 4'h0;
	// Sizes and answers
	localparam int FIFO_DEPTH = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic {IPF_DMA_IDLE, IPF_DMA_WRITE} ipf_dma_state_t;
endpackage

// ---- design/ipf_port_top.sv ----
// Purpose: Audio input port: channels into shared FIFO, drained by core or DMA.
// Assumes: AXI4-Lite slave, one read and one write outstanding.
// Notes: Channel 0 is taken by the parallel unit while it is enabled.
`timescale 1ns/1ps
module ipf_port_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] ser_bit_clock,
	input wire logic [7:0] ser_frame_sync,
	input wire logic [7:0] ser_data,
	input wire logic par_clock,
	input wire logic parallel_clock_hold_input,
	input wire logic [19:0] par_data,
	output logic mem_wr_valid_q,
	output logic [31:0] mem_wr_addr_q,
	output logic [31:0] mem_wr_data_q,
	input wire logic mem_wr_ready,
	output logic irq_low_q,
	output logic irq_high_q
);
	// Control state
	logic [3:0] fifo_threshold_value;
	logic read_stall_disable, port_global_enable, global_transfer_enable;
	logic [23:0] ctl1_q;
	logic parallel_capture_enable, pp_edge_q;
	logic [1:0] pp_mode_q;
	logic [17:0] re_mask_q, fe_mask_q, pri_q;
	logic [7:0] done_lat_q, ovf_q, channel_transfer_active, arm_q;
	wire [7:0] channel_input_enable = ctl1_q[7:0];
	wire [7:0] channel_transfer_enable = ctl1_q[ipf_pkg::CTL1_CHDMA_LSB +: 8];
	wire [7:0] channel_double_buffer_select = ctl1_q[ipf_pkg::CTL1_PING_LSB +: 8];

	// Shared FIFO, data plus channel tag
	logic [34:0] fifo_q [ipf_pkg::FIFO_DEPTH];
	logic [2:0] wr_ptr_q, rd_ptr_q;
	logic [3:0] count_q;
	wire fifo_empty = (count_q == 4'd0);
	wire fifo_full = (count_q == 4'd8);
	wire [34:0] head = fifo_q[rd_ptr_q];
	wire [2:0] head_ch = head[34:32];

	// Transfer parameters and working copies
	logic [31:0] idx_a_q [8];
	logic [31:0] idx_b_q [8];
	logic [31:0] mod_q [8];
	logic [15:0] cnt_q [8];
	logic [31:0] cur_idx_q [8];
	logic [15:0] cur_cnt_q [8];
	logic [7:0] buf_sel_q;

	// Bus slave state
	logic aw_hold_q, w_hold_q, ar_hold_q;
	logic [11:0] awaddr_q, araddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	// Write address decode
	wire wr_do = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	wire wr_full = (wstrb_q == 4'hf);
	wire [31:0] wd = wdata_q;
	wire wr_prm = (awaddr_q[11:8] == ipf_pkg::PRM_PAGE) & (awaddr_q[7] == 1'b0);
	wire [2:0] prm_ch = awaddr_q[6:4];
	wire [1:0] prm_slot = awaddr_q[3:2];
	wire wr_ok = wr_do & wr_full;
	wire wr_ctl0 = wr_ok & (awaddr_q == ipf_pkg::OFF_CTL0);
	wire wr_ctl1 = wr_ok & (awaddr_q == ipf_pkg::OFF_CTL1);
	wire wr_pp = wr_ok & (awaddr_q == ipf_pkg::OFF_PP_CTL);
	wire wr_fifo = wr_ok & (awaddr_q == ipf_pkg::OFF_FIFO);
	wire wr_re = wr_ok & (awaddr_q == ipf_pkg::OFF_RE_MASK);
	wire wr_fe = wr_ok & (awaddr_q == ipf_pkg::OFF_FE_MASK);
	wire wr_pri = wr_ok & (awaddr_q == ipf_pkg::OFF_PRI);
	wire wr_p = wr_ok & wr_prm & (awaddr_q[1:0] == 2'b00);
	wire wr_hit = wr_ctl0 | wr_ctl1 | wr_pp | wr_fifo | wr_re | wr_fe | wr_pri | wr_p;
	wire clr_ovf = wr_ctl0 & wd[ipf_pkg::CTL0_CLR_OVF_BIT];

	// Event vector: completions 17-10, threshold at bit 8
	logic thr_level;
	wire dma_running = global_transfer_enable & (|channel_transfer_enable);
	assign thr_level = (count_q > {1'b0, fifo_threshold_value}) & ~dma_running;
	wire thr_bit = thr_level & re_mask_q[ipf_pkg::EV_THR_BIT] &
		~fe_mask_q[ipf_pkg::EV_THR_BIT];
	wire [17:0] ev_vec = {done_lat_q, 1'b0, thr_bit, 8'h00};
	wire [17:0] lat_low = ev_vec & ~pri_q;
	wire [17:0] lat_high = ev_vec & pri_q;

	// Read side: FIFO reads may wait for data
	wire rd_fifo = (araddr_q == ipf_pkg::OFF_FIFO);
	logic dma_pop;
	wire rd_ready = ~fifo_empty | read_stall_disable;
	wire rd_do = ar_hold_q & ~s_axi_rvalid & (~rd_fifo | (rd_ready & ~dma_pop));
	wire core_pop = rd_do & rd_fifo & ~fifo_empty;
	wire rd_lat_low = rd_do & (araddr_q == ipf_pkg::OFF_LAT_LOW);
	wire rd_lat_high = rd_do & (araddr_q == ipf_pkg::OFF_LAT_HIGH);

	// Channel sources, parallel unit replaces channel 0 when enabled
	logic [7:0] ser_valid, ch_ack;
	logic [31:0] ser_word [8];
	logic par_valid;
	logic [31:0] par_word;
	logic [7:0] src_valid;
	logic [31:0] src_word [8];
	wire [7:0] ch_on = {8{port_global_enable}} & channel_input_enable;
	wire par_on = ch_on[0] & parallel_capture_enable;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gen_ch
			ipf_serial_rx u_rx (
				.aclk(aclk),
				.aresetn(aresetn),
				.en(ch_on[g] & ~((g == 0) & parallel_capture_enable)),
				.bit_clock(ser_bit_clock[g]),
				.frame_sync(ser_frame_sync[g]),
				.data_in(ser_data[g]),
				.ack(ch_ack[g]),
				.word_valid_q(ser_valid[g]),
				.word_q(ser_word[g])
			);
			if (g == 0) begin : gen_mux0
				assign src_valid[g] = parallel_capture_enable ? par_valid : ser_valid[g];
				assign src_word[g] = parallel_capture_enable ? par_word : ser_word[g];
			end else begin : gen_pass
				assign src_valid[g] = ser_valid[g];
				assign src_word[g] = ser_word[g];
			end
		end
	endgenerate

	ipf_parallel_rx u_par (
		.aclk(aclk),
		.aresetn(aresetn),
		.en(par_on),
		.fall_edge(pp_edge_q),
		.mode(pp_mode_q),
		.cap_clock(par_clock),
		.hold(parallel_clock_hold_input),
		.cap_data(par_data),
		.ack(ch_ack[0] & parallel_capture_enable),
		.word_valid_q(par_valid),
		.word_q(par_word)
	);

	// Lowest pending channel is granted, core write goes first
	logic [2:0] grant;
	logic grant_ok;
	always_comb begin
		grant = 3'd0;
		grant_ok = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (src_valid[i]) begin
				grant = 3'(i);
				grant_ok = 1'b1;
			end
		end
	end
	wire ch_push = grant_ok & ~wr_fifo;
	assign ch_ack = ch_push ? (8'h01 << grant) : 8'h00;
	wire push = (wr_fifo | ch_push) & ~fifo_full;
	wire [34:0] push_word = wr_fifo ? {wd[2:0], wd} : {grant, src_word[grant]};
	wire pop = dma_pop | core_pop;

	// FIFO storage and pointers; disabling the port flushes it
	always_ff @(posedge aclk) begin
		if (!aresetn || !port_global_enable) begin
			wr_ptr_q <= 3'd0;
			rd_ptr_q <= 3'd0;
			count_q <= 4'd0;
		end else begin
			if (push) begin
				fifo_q[wr_ptr_q] <= push_word;
				wr_ptr_q <= wr_ptr_q + 3'd1;
			end
			if (pop)
				rd_ptr_q <= rd_ptr_q + 3'd1;
			count_q <= count_q + {3'd0, push} - {3'd0, pop};
		end
	end

	// Sticky overflow per channel, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ovf_q <= 8'h00;
		else
			ovf_q <= (clr_ovf ? 8'h00 : ovf_q) | ((ch_push & fifo_full) ? ch_ack : 8'h00);
	end

	// Transfer engine: one word from FIFO head to memory at a time
	ipf_pkg::ipf_dma_state_t state_q;
	logic [2:0] dch_q;
	wire xfer_done = (state_q == ipf_pkg::IPF_DMA_WRITE) & mem_wr_ready;
	wire head_live = channel_transfer_enable[head_ch] & channel_transfer_active[head_ch];
	assign dma_pop = (state_q == ipf_pkg::IPF_DMA_IDLE) & global_transfer_enable & ~fifo_empty;
	wire [15:0] cnt_next = cur_cnt_q[dch_q] - 16'd1;
	wire last_word = xfer_done & (cnt_next == 16'd0);
	wire [7:0] done_evt = last_word ? (8'h01 << dch_q) : 8'h00;

	// Words of finished channels are dropped so others keep moving
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ipf_pkg::IPF_DMA_IDLE;
			dch_q <= 3'd0;
			mem_wr_valid_q <= 1'b0;
			mem_wr_addr_q <= 32'h0;
			mem_wr_data_q <= 32'h0;
		end else begin
			case (state_q)
				ipf_pkg::IPF_DMA_IDLE: begin
					if (dma_pop && head_live) begin
						dch_q <= head_ch;
						mem_wr_addr_q <= cur_idx_q[head_ch];
						mem_wr_data_q <= head[31:0];
						mem_wr_valid_q <= 1'b1;
						state_q <= ipf_pkg::IPF_DMA_WRITE;
					end
				end
				ipf_pkg::IPF_DMA_WRITE: begin
					// Runs out even if the enables drop meanwhile
					if (mem_wr_ready) begin
						mem_wr_valid_q <= 1'b0;
						state_q <= ipf_pkg::IPF_DMA_IDLE;
					end
				end
				default: state_q <= ipf_pkg::IPF_DMA_IDLE;
			endcase
		end
	end

	// Parameter slots, working index and count per channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 8; i++) begin
				idx_a_q[i] <= 32'h0;
				idx_b_q[i] <= 32'h0;
				mod_q[i] <= 32'h0;
				cnt_q[i] <= 16'h0;
				cur_idx_q[i] <= 32'h0;
				cur_cnt_q[i] <= 16'h0;
			end
			buf_sel_q <= 8'h00;
		end else begin
			if (xfer_done) begin
				cur_idx_q[dch_q] <= cur_idx_q[dch_q] + mod_q[dch_q];
				cur_cnt_q[dch_q] <= cnt_next;
				if (last_word && channel_double_buffer_select[dch_q]) begin
					buf_sel_q[dch_q] <= ~buf_sel_q[dch_q];
					cur_idx_q[dch_q] <= buf_sel_q[dch_q] ? idx_a_q[dch_q] : idx_b_q[dch_q];
					cur_cnt_q[dch_q] <= cnt_q[dch_q];
				end
			end
			if (wr_p) begin
				case (prm_slot)
					ipf_pkg::PRM_IDX_A: begin
						idx_a_q[prm_ch] <= wd;
						cur_idx_q[prm_ch] <= wd;
						buf_sel_q[prm_ch] <= 1'b0;
					end
					ipf_pkg::PRM_IDX_B: idx_b_q[prm_ch] <= wd;
					ipf_pkg::PRM_MOD: mod_q[prm_ch] <= wd;
					ipf_pkg::PRM_CNT: begin
						cnt_q[prm_ch] <= wd[15:0];
						cur_cnt_q[prm_ch] <= wd[15:0];
					end
					default: ;
				endcase
			end
		end
	end

	// Active bit armed on enable rise for programmed channels, clears at last word of single-buffered channels
	wire [7:0] en_now = {8{global_transfer_enable}} & channel_transfer_enable;
	logic [7:0] prog;
	always_comb begin
		for (int i = 0; i < 8; i++)
			prog[i] = (cnt_q[i] != 16'h0);
	end
	wire [7:0] single_done = done_evt & ~channel_double_buffer_select;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arm_q <= 8'h00;
			channel_transfer_active <= 8'h00;
		end else begin
			arm_q <= en_now;
			channel_transfer_active <= (channel_transfer_active & ~single_done) |
				(en_now & ~arm_q & prog);
		end
	end

	// Completion latches: read clears, a new completion wins
	wire [7:0] done_set = done_evt & re_mask_q[ipf_pkg::EV_DONE_LSB +: 8];
	wire [7:0] clr_low = rd_lat_low ? ~pri_q[ipf_pkg::EV_DONE_LSB +: 8] : 8'h00;
	wire [7:0] clr_high = rd_lat_high ? pri_q[ipf_pkg::EV_DONE_LSB +: 8] : 8'h00;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_lat_q <= 8'h00;
			irq_low_q <= 1'b0;
			irq_high_q <= 1'b0;
		end else begin
			done_lat_q <= (done_lat_q & ~clr_low & ~clr_high) | done_set;
			irq_low_q <= |lat_low;
			irq_high_q <= |lat_high;
		end
	end

	// Control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fifo_threshold_value <= ipf_pkg::NSET_RST;
			read_stall_disable <= 1'b0;
			port_global_enable <= 1'b0;
			global_transfer_enable <= 1'b0;
			ctl1_q <= ipf_pkg::CTL1_RST;
			parallel_capture_enable <= 1'b0;
			pp_edge_q <= 1'b0;
			pp_mode_q <= 2'd0;
			re_mask_q <= ipf_pkg::EV_RST;
			fe_mask_q <= ipf_pkg::EV_RST;
			pri_q <= ipf_pkg::EV_RST;
		end else begin
			if (wr_ctl0) begin
				fifo_threshold_value <= wd[ipf_pkg::CTL0_NSET_LSB +: 4];
				read_stall_disable <= wd[ipf_pkg::CTL0_STALL_DIS_BIT];
				port_global_enable <= wd[ipf_pkg::CTL0_PORT_EN_BIT];
				global_transfer_enable <= wd[ipf_pkg::CTL0_GDMA_BIT];
			end
			if (wr_ctl1)
				ctl1_q <= wd[23:0];
			if (wr_pp) begin
				parallel_capture_enable <= wd[ipf_pkg::PP_EN_BIT];
				pp_edge_q <= wd[ipf_pkg::PP_EDGE_BIT];
				pp_mode_q <= wd[ipf_pkg::PP_MODE_LSB +: 2];
			end
			if (wr_re)
				re_mask_q <= wd[17:0];
			if (wr_fe)
				fe_mask_q <= wd[17:0];
			if (wr_pri)
				pri_q <= wd[17:0];
		end
	end

	// Read data selection
	logic [31:0] rd_word;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0;
		case (araddr_q)
			ipf_pkg::OFF_CTL0: rd_word = {23'h0, global_transfer_enable, port_global_enable,
				2'b00, read_stall_disable, fifo_threshold_value};
			ipf_pkg::OFF_CTL1: rd_word = {8'h00, ctl1_q};
			ipf_pkg::OFF_PP_CTL: rd_word = {parallel_capture_enable, 1'b0, pp_edge_q,
				1'b0, pp_mode_q, 26'h0};
			ipf_pkg::OFF_FIFO: rd_word = fifo_empty ? 32'h0 : head[31:0];
			ipf_pkg::OFF_PTR_STAT: rd_word = {20'h0, count_q, 1'b0, wr_ptr_q,
				1'b0, rd_ptr_q};
			ipf_pkg::OFF_RE_MASK: rd_word = {14'h0, re_mask_q};
			ipf_pkg::OFF_FE_MASK: rd_word = {14'h0, fe_mask_q};
			ipf_pkg::OFF_PRI: rd_word = {14'h0, pri_q};
			ipf_pkg::OFF_LAT_LOW: rd_word = {14'h0, lat_low};
			ipf_pkg::OFF_LAT_HIGH: rd_word = {14'h0, lat_high};
			ipf_pkg::OFF_ROUTE_STAT: rd_word = {7'h0, channel_transfer_active, 9'h0, ovf_q};
			default: begin
				rd_hit = 1'b0;
				if ((araddr_q[11:8] == ipf_pkg::PRM_PAGE) && !araddr_q[7] && araddr_q[1:0] == 2'b00) begin
					rd_hit = 1'b1;
					case (araddr_q[3:2])
						ipf_pkg::PRM_IDX_A: rd_word = idx_a_q[araddr_q[6:4]];
						ipf_pkg::PRM_IDX_B: rd_word = idx_b_q[araddr_q[6:4]];
						ipf_pkg::PRM_MOD: rd_word = mod_q[araddr_q[6:4]];
						default: rd_word = {16'h0, cur_cnt_q[araddr_q[6:4]]};
					endcase
				end
			end
		endcase
	end

	// Write channels: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ipf_pkg::RESP_OKAY;
			awaddr_q <= 12'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			s_axi_awready <= ~aw_hold_q & ~(s_axi_awvalid & s_axi_awready) | wr_do;
			s_axi_wready <= ~w_hold_q & ~(s_axi_wvalid & s_axi_wready) | wr_do;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr[11:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? ipf_pkg::RESP_OKAY : ipf_pkg::RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: empty FIFO read waits here while stalling is allowed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_hold_q <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= ipf_pkg::RESP_OKAY;
			araddr_q <= 12'h0;
		end else begin
			// Stays low from the taken edge until the answer is taken
			s_axi_arready <= ~ar_hold_q & ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				ar_hold_q <= 1'b1;
				araddr_q <= s_axi_araddr[11:0];
			end
			if (rd_do) begin
				ar_hold_q <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? ipf_pkg::RESP_OKAY : ipf_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// ---- design/ipf_serial_rx.sv ----
// Purpose: One serial input channel: sync, shift, frame into words.
// Assumes: Bit clock well below aclk/3; word ends on frame sync change.
// Notes: Word held until acknowledged; a newer word overwrites it.
`timescale 1ns/1ps
module ipf_serial_rx (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic en,
	input wire logic bit_clock,
	input wire logic frame_sync,
	input wire logic data_in,
	input wire logic ack,
	output logic word_valid_q,
	output logic [31:0] word_q
);
	logic [2:0] s1_q, s2_q, s3_q, st_q, prev_q;
	logic [31:0] shift_q;
	logic fs_last_q;
	// Bit only moves once second and third stages agree
	wire [2:0] st_d = (s2_q & ~(s2_q ^ s3_q)) | (st_q & (s2_q ^ s3_q));
	wire rise = st_q[0] & ~prev_q[0];
	wire boundary = rise & (st_q[1] != fs_last_q);

	// Synchroniser chain
	always_ff @(posedge aclk) begin
		s1_q <= {data_in, frame_sync, bit_clock};
		s2_q <= s1_q;
		s3_q <= s2_q;
		st_q <= st_d;
		prev_q <= st_q;
	end

	// Shift on bit clock rise, close word on frame edge
	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			shift_q <= 32'h0;
			word_q <= 32'h0;
			word_valid_q <= 1'b0;
			fs_last_q <= 1'b0;
		end else begin
			if (ack)
				word_valid_q <= 1'b0;
			if (rise) begin
				fs_last_q <= st_q[1];
				shift_q <= boundary ? {31'h0, st_q[2]} : {shift_q[30:0], st_q[2]};
			end
			if (boundary) begin
				word_q <= shift_q;
				word_valid_q <= 1'b1; // New word wins over ack
			end
		end
	end
endmodule

// ---- dv/ipf_mem_model.sv ----
// Purpose: Memory side of the transfer engine.
// Assumes: Ready alternates, so some words wait.
// Notes: Counts words and keeps the first one.
`timescale 1ns/1ps
module ipf_mem_model (
	input wire logic aclk,
	input wire logic valid,
	input wire logic [31:0] data,
	output logic ready,
	output int n,
	output logic [31:0] d0
);
	initial ready = 1'b0;
	initial n = 0;
	// Toggling ready gives prompt and slow answers
	always @(posedge aclk) begin
		ready <= ~ready;
		if (valid && ready) begin
			if (n == 0) d0 <= data;
			n <= n + 1;
		end
	end
endmodule

// ---- dv/ipf_monitor.sv ----
// Purpose: Handshake checks on the port top.
// Assumes: One clock domain, reset active low.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module ipf_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic mem_wr_valid_q,
	input wire logic mem_wr_ready,
	input wire logic [31:0] mem_wr_addr_q
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Answers stand until taken
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bh: assert property (p_bh) else $error("write answer dropped");
	property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
	a_rh: assert property (p_rh) else $error("read answer dropped");
	property p_mh; mem_wr_valid_q && !mem_wr_ready |=> $stable(mem_wr_addr_q); endproperty
	a_mh: assert property (p_mh) else $error("memory word moved");
	// Answer timing; FIFO reads may stall, so they are left out
	property p_ba; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid; endproperty
	a_ba: assert property (p_ba) else $error("write not answered");
	property p_ra; s_axi_arvalid && s_axi_arready && s_axi_araddr[11:0] != 12'h00c
		|-> ##2 s_axi_rvalid; endproperty
	a_ra: assert property (p_ra) else $error("read not answered");
	property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bd: assert property (p_bd) else $error("write answer repeated");
	// No write address taken the cycle after one; no read taken while a read answer waits
	property p_ab; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
	a_ab: assert property (p_ab) else $error("write taken while busy");
	property p_rb; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rb: assert property (p_rb) else $error("read taken while busy");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_mem: cover property (mem_wr_valid_q && !mem_wr_ready);
endmodule

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench of the port top.
// Assumes: Serial inputs idle low; memory model answers.
// Notes: Capture clock runs free while capture is off.
`timescale 1ns/1ps
module testbench;
	logic aclk = 1'b0, aresetn = 1'b0, par_clock = 1'b0, parallel_clock_hold_input = 1'b1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [31:0] s_axi_rdata, mem_wr_addr_q, mem_wr_data_q, rv, d0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic mem_wr_valid_q, mem_wr_ready, irq_low_q, irq_high_q;
	int errors = 0, samples_checked = 0, n_mem;
	always #2 aclk = ~aclk;
	// Link clock, phase unrelated to aclk
	initial begin
		#0.7;
		forever #40 par_clock = ~par_clock;
	end
	ipf_port_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ser_bit_clock(8'h00),
		.ser_frame_sync(8'h00), .ser_data(8'h00), .par_clock, .parallel_clock_hold_input,
		.par_data(20'h00005), .mem_wr_valid_q, .mem_wr_addr_q, .mem_wr_data_q, .mem_wr_ready,
		.irq_low_q, .irq_high_q);
	ipf_mem_model u_mem (.aclk, .valid(mem_wr_valid_q), .data(mem_wr_data_q),
		.ready(mem_wr_ready), .n(n_mem), .d0);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= {20'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask
	task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge aclk);
		s_axi_araddr <= {20'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rv = s_axi_rdata;
		chk(nm, e, rv & m);
	endtask
	// Core pushes, pointer view and threshold level
	task automatic t_fifo;
		wr(12'h014, 32'h100, 2'b00);
		wr(12'h000, 32'h81, 2'b00);
		wr(12'h00c, 32'h15, 2'b00);
		wr(12'h00c, 32'h23, 2'b00);
		wr(12'h00c, 32'h32, 2'b00);
		rd(12'h010, "ptrs", 32'h330, '1);
		rd(12'h020, "thr", 32'h100, '1);
		rd(12'h020, "thr again", 32'h100, '1);
		chk("irq low", 32'h1, {31'h0, irq_low_q});
		rd(12'h00c, "pop", 32'h15, '1);
		rd(12'h00c, "pop", 32'h23, '1);
		rd(12'h020, "thr off", 32'h0, '1);
	endtask
	// Flush on disable, capture clock hold, non-stalling empty read
	task automatic t_flush;
		wr(12'h004, 32'h1, 2'b00);
		wr(12'h008, 32'h0, 2'b00);
		parallel_clock_hold_input <= 1'b0;
		wr(12'h000, 32'h0, 2'b00);
		wr(12'h000, 32'h90, 2'b00);
		repeat (200) @(posedge aclk);
		rd(12'h010, "count", 32'h0, 32'hf00);
		// Ten capture edges in 200 cycles, so the FIFO fills
		wr(12'h008, 32'h80000000, 2'b00);
		repeat (200) @(posedge aclk);
		rd(12'h010, "full", 32'h800, 32'hf00);
		rd(12'h00c, "par word", 32'h5, '1);
		parallel_clock_hold_input <= 1'b1;
		wr(12'h000, 32'h0, 2'b00);
		wr(12'h000, 32'h90, 2'b00);
		repeat (200) @(posedge aclk);
		rd(12'h010, "held", 32'h0, 32'hf00);
		rd(12'h00c, "empty pop", 32'h0, '1);
		rd(12'h010, "ptrs kept", 32'h0, '1);
	endtask
	// One standard transfer of two words to memory
	task automatic t_dma;
		wr(12'h000, 32'h0, 2'b00);
		wr(12'h100, 32'h1000, 2'b00);
		wr(12'h108, 32'h4, 2'b00);
		wr(12'h10c, 32'h2, 2'b00);
		wr(12'h014, 32'h400, 2'b00);
		wr(12'h004, 32'h101, 2'b00);
		wr(12'h000, 32'h100, 2'b00);
		wr(12'h000, 32'h180, 2'b00);
		wr(12'h00c, 32'h8, 2'b00);
		wr(12'h00c, 32'h10, 2'b00);
		for (int i = 0; i < 100 && irq_low_q !== 1'b1; i++) @(posedge aclk);
		wr(12'h000, 32'h80, 2'b00);
		wr(12'h004, 32'h1, 2'b00);
		rd(12'h028, "active", 32'h0, 32'h20000);
		rd(12'h020, "done", 32'h400, 32'h400);
		rd(12'h020, "done clr", 32'h0, 32'h400);
		chk("words", 32'h2, n_mem);
		chk("first", 32'h8, d0);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		wr(12'h02c, 32'h1, 2'b10);
		rd(12'h004, "ctl1 rst", 32'h0, '1);
		t_fifo;
		t_flush;
		t_dma;
		tally_and_finish;
	end
	// Watchdog
	initial begin
		#20000;
		errors++;
		tally_and_finish;
	end
endmodule
bind ipf_port_top ipf_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .mem_wr_valid_q,
	.mem_wr_ready, .mem_wr_addr_q);
